// File: src/pmh_handler.v
// Power mode message handler: request decode, replies, power controls
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
`include "pmh_map.vh"
module pmh_handler (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire wake_pin,
	output reg irq,
	output reg radio_mode,
	output reg tx_enable,
	output reg rx_enable,
	output reg amp_enable,
	output reg baseband_run,
	output reg baseband_clk_en,
	output reg front_end_power,
	output reg eth_phy_power,
	output reg eth_cmd_accept,
	output reg serial_cmd_accept
);
// ----------------------------------------
// Registers
// ----------------------------------------
reg [2:0] mode;
reg connected;
reg scanning;
reg [15:0] req_type;
reg [15:0] req_track;
reg [31:0] req_arg;
reg [15:0] req_len;
reg req_serial;
reg [15:0] rsp_type;
reg [15:0] rsp_track;
reg [31:0] rsp_mode;
reg [31:0] rsp_stat;
reg [1:0] irq_stat;
reg [1:0] irq_en;
reg [30:0] fault_code;
reg fault;
reg [15:0] last_track;
reg wk1;
reg wk2;
reg wk3;
reg go;
reg [31:0] st;
wire apb_acc = psel & penable;
// Writes land on the completing edge, where the registered ready is high
wire wr = apb_acc & pwrite & pready;
wire rd = apb_acc & ~pwrite;
wire wr_wait = apb_acc & pwrite & ~pready;
wire irq_clr_wr = wr & (paddr == `PMH_A_IRQ_CLR);
wire [1:0] irq_clr = irq_clr_wr ? pwdata[1:0] : 2'h0;
reg wake_prev;
// Wake pin edge counts only once stages two and three agree
wire wake_rise = wk2 & wk3 & ~wake_prev;
wire asleep = (mode != `PMH_M_ACTIVE);
wire ready_evt = (mode == `PMH_M_SLEEP_D) & wake_rise;
wire known = (req_type == `PMH_T_QUERY) | (req_type == `PMH_T_SETCMD) |
	(req_type == `PMH_T_SCAN) | (req_type == `PMH_T_PARAM);
wire [15:0] want_len = (req_type == `PMH_T_QUERY) ? `PMH_LEN_SHORT : `PMH_LEN_SET;
// Ports allowed by current power state
wire port_ok = req_serial ? 1'b1 : (mode != `PMH_M_STBY_S);
// ----------------------------------------
// Status selection
// ----------------------------------------
always @* begin
	// First failing check decides the code
	st = `PMH_S_OK;
	if (fault) begin
		st = `PMH_S_INTERNAL | {1'b0, fault_code};
	end else if (!known) begin
		st = `PMH_S_UNKNOWN;
	end else if (req_len != want_len) begin
		st = `PMH_S_SIZE;
	// Discrete sleep left only by the pin
	end else if (mode == `PMH_M_SLEEP_D) begin
		st = `PMH_S_SLEEP;
	// Serial-only standby refuses ethernet requests
	end else if (!port_ok) begin
		st = `PMH_S_GENERIC;
	end else if ((req_type == `PMH_T_SCAN || req_type == `PMH_T_PARAM) && asleep) begin
		st = `PMH_S_SLEEP;
	end else if (req_type == `PMH_T_SCAN && !connected) begin
		st = `PMH_S_OPMODE;
	end else if (req_type == `PMH_T_SETCMD && req_arg > {29'h0, `PMH_M_SLEEP_D}) begin
		st = `PMH_S_VALUE;
	end
end
// ----------------------------------------
// Wake pin synchroniser
// ----------------------------------------
// First stage may go metastable; only stage two reads it
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		wk1 <= 1'b0;
		wk2 <= 1'b0;
		wk3 <= 1'b0;
		wake_prev <= 1'b0;
	end else begin
		wk1 <= wake_pin;
		wk2 <= wk1;
		wk3 <= wk2;
		// Agreed level only, so a one-cycle glitch never counts
		if (wk2 == wk3) begin
			wake_prev <= wk3;
		end
	end
end
// ----------------------------------------
// Request capture
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		req_type <= 16'h0000;
		req_track <= 16'h0000;
		req_arg <= 32'h00000000;
		req_len <= 16'h0000;
		req_serial <= 1'b0;
		fault <= 1'b0;
		fault_code <= 31'h00000000;
		go <= 1'b0;
	end else begin
		// One pulse per GO write, since a write lands only once
		go <= wr && (paddr == `PMH_A_REQ_GO);
		if (wr) begin
			case (paddr)
				`PMH_A_REQ_HDR: begin
					req_type <= pwdata[31:16];
					req_track <= pwdata[15:0];
				end
				`PMH_A_REQ_ARG: req_arg <= pwdata;
				`PMH_A_REQ_LEN: begin
					req_len <= pwdata[15:0];
					req_serial <= pwdata[16];
				end
				// Test hook: injects an internal error code
				`PMH_A_FAULT: begin
					fault <= pwdata[31];
					fault_code <= pwdata[30:0];
				end
				default: begin
				end
			endcase
		end
	end
end
// ----------------------------------------
// Interrupt status and enable
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		irq_stat <= 2'h0;
		irq_en <= 2'h0;
	end else begin
		// Enable bits gate only the line, never the flags
		if (wr && (paddr == `PMH_A_IRQ_EN)) begin
			irq_en <= pwdata[1:0];
		end
		// Set beats clear on the sticky flags
		irq_stat <= (irq_stat & ~irq_clr) | {ready_evt, go};
	end
end
// ----------------------------------------
// Mode, scan and reply
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		mode <= `PMH_M_ACTIVE;
		connected <= 1'b0;
		scanning <= 1'b0;
		rsp_type <= 16'h0000;
		rsp_track <= 16'h0000;
		rsp_mode <= 32'h00000000;
		rsp_stat <= 32'h00000000;
		last_track <= 16'h0000;
	end else begin
		// A scan start in the same edge still wins
		if (wr && (paddr == `PMH_A_CTRL) && pwdata[`PMH_B_SCAN_STOP]) begin
			scanning <= 1'b0;
		end
		if (go) begin
			rsp_track <= req_track;
			last_track <= req_track;
			rsp_stat <= st;
			if (port_ok) begin
				connected <= 1'b1;
			end
			if (req_type == `PMH_T_QUERY) begin
				rsp_type <= `PMH_T_REPORT;
			end else if (req_type == `PMH_T_SETCMD) begin
				rsp_type <= `PMH_T_SETREPLY;
			end else begin
				rsp_type <= req_type | 16'h0100;
			end
			rsp_mode <= {29'h0, mode};
			if (st == `PMH_S_OK) begin
				if (req_type == `PMH_T_SETCMD) begin
					mode <= req_arg[2:0];
					scanning <= 1'b0;
				end
				if (req_type == `PMH_T_SCAN) begin
					scanning <= 1'b1;
				end
			end
		end else if (ready_evt) begin
			mode <= `PMH_M_ACTIVE;
			rsp_type <= `PMH_T_READY;
			rsp_track <= last_track;
			rsp_mode <= 32'h00000000;
			rsp_stat <= `PMH_S_OK;
		end
	end
end
// ----------------------------------------
// APB read and outputs
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= 32'h00000000;
		pready <= 1'b0;
		pslverr <= 1'b0;
	end else begin
		// One wait state: ready answers in the second access cycle
		pready <= apb_acc & ~pready;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
		if (rd && !pready) begin
			case (paddr)
				`PMH_A_CTRL: prdata <= {31'h0, connected};
				`PMH_A_STATUS: prdata <= {27'h0, scanning, connected, mode};
				`PMH_A_REQ_HDR: prdata <= {req_type, req_track};
				`PMH_A_REQ_ARG: prdata <= req_arg;
				`PMH_A_REQ_LEN: prdata <= {15'h0, req_serial, req_len};
				`PMH_A_RSP_HDR: prdata <= {rsp_type, rsp_track};
				`PMH_A_RSP_MODE: prdata <= rsp_mode;
				`PMH_A_RSP_STAT: prdata <= rsp_stat;
				`PMH_A_IRQ_STAT: prdata <= {30'h0, irq_stat};
				`PMH_A_IRQ_EN: prdata <= {30'h0, irq_en};
				`PMH_A_POWER: prdata <= {22'h0, radio_mode, tx_enable, rx_enable, amp_enable,
					baseband_run, baseband_clk_en, front_end_power, eth_phy_power,
					eth_cmd_accept, serial_cmd_accept};
				`PMH_A_FAULT: prdata <= {fault, fault_code};
				`PMH_A_REQ_GO, `PMH_A_IRQ_CLR: prdata <= 32'h00000000;
				default: pslverr <= 1'b1;
			endcase
		end else if (wr_wait) begin
			// Writes to read-only or unmapped offsets raise pslverr
			case (paddr)
				`PMH_A_CTRL, `PMH_A_REQ_HDR, `PMH_A_REQ_ARG, `PMH_A_REQ_LEN, `PMH_A_REQ_GO,
				`PMH_A_IRQ_CLR, `PMH_A_IRQ_EN, `PMH_A_FAULT: pslverr <= 1'b0;
				default: pslverr <= 1'b1;
			endcase
		end
	end
end
// ----------------------------------------
// Interrupt line
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		irq <= 1'b0;
	end else begin
		// Level output, one edge behind the flags
		irq <= |(irq_stat & irq_en);
	end
end
// ----------------------------------------
// Power controls
// ----------------------------------------
// Registered, so each control lags its mode change by one edge
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		radio_mode <= 1'b1;
		tx_enable <= 1'b0;
		rx_enable <= 1'b1;
		amp_enable <= 1'b0;
		baseband_run <= 1'b0;
		baseband_clk_en <= 1'b1;
		front_end_power <= 1'b1;
		eth_phy_power <= 1'b1;
		eth_cmd_accept <= 1'b1;
		serial_cmd_accept <= 1'b1;
	end else begin
		radio_mode <= ~connected;
		// Full tx and rx while scanning
		tx_enable <= scanning & (mode == `PMH_M_ACTIVE);
		rx_enable <= (mode == `PMH_M_ACTIVE);
		amp_enable <= scanning & (mode == `PMH_M_ACTIVE);
		baseband_run <= connected & (mode == `PMH_M_ACTIVE);
		// Standby E gates clock, front end
		baseband_clk_en <= (mode == `PMH_M_ACTIVE) | (mode == `PMH_M_IDLE);
		front_end_power <= (mode == `PMH_M_ACTIVE) | (mode == `PMH_M_IDLE);
		// Standby S drops PHY and ethernet
		eth_phy_power <= (mode != `PMH_M_STBY_S) & (mode != `PMH_M_SLEEP_D);
		eth_cmd_accept <= (mode != `PMH_M_STBY_S) & (mode != `PMH_M_SLEEP_D);
		serial_cmd_accept <= (mode != `PMH_M_SLEEP_D);
	end
end
endmodule // pmh_handler

// File: src/pmh_map.vh
// Constants for the power mode message handler
`ifndef PMH_MAP_VH
`define PMH_MAP_VH
// Message type codes
`define PMH_T_QUERY 16'hf006
`define PMH_T_SETCMD 16'hf005
`define PMH_T_SETREPLY 16'hf105
`define PMH_T_REPORT 16'hf106
`define PMH_T_READY 16'hf202
`define PMH_T_SCAN 16'hf003
`define PMH_T_PARAM 16'h1001
// Power modes
`define PMH_M_ACTIVE 3'h0
`define PMH_M_IDLE 3'h1
`define PMH_M_STBY_E 3'h2
`define PMH_M_STBY_S 3'h3
`define PMH_M_SLEEP_D 3'h4
// Status codes
`define PMH_S_OK 32'h00000000
`define PMH_S_GENERIC 32'h00000001
`define PMH_S_OPMODE 32'h00000002
`define PMH_S_VALUE 32'h00000003
`define PMH_S_SLEEP 32'h00000004
`define PMH_S_SIZE 32'h00000005
`define PMH_S_DISABLED 32'h00000006
`define PMH_S_BUFSIZE 32'h00000007
`define PMH_S_UNKNOWN 32'h00000008
`define PMH_S_INTERNAL 32'h80000000
// Request byte counts
`define PMH_LEN_SHORT 16'h0004
`define PMH_LEN_SET 16'h0008
// APB offsets
`define PMH_A_CTRL 12'h000
`define PMH_A_STATUS 12'h004
`define PMH_A_REQ_HDR 12'h008
`define PMH_A_REQ_ARG 12'h00c
`define PMH_A_REQ_LEN 12'h010
`define PMH_A_REQ_GO 12'h014
`define PMH_A_RSP_HDR 12'h018
`define PMH_A_RSP_MODE 12'h01c
`define PMH_A_RSP_STAT 12'h020
`define PMH_A_IRQ_STAT 12'h024
`define PMH_A_IRQ_CLR 12'h028
`define PMH_A_IRQ_EN 12'h02c
`define PMH_A_POWER 12'h030
`define PMH_A_FAULT 12'h034
// Bit positions
`define PMH_B_CONNECT 0
`define PMH_B_SCAN_STOP 1
`define PMH_B_SERIAL 2
`define PMH_B_IRQ_RSP 0
`define PMH_B_IRQ_READY 1
`endif

// File: testbench/pmh_handler_asserts.sv
// Power control checks for the message handler
`timescale 1ns/1ps
module pmh_handler_asserts (
	input wire pclk,
	input wire presetn,
	input wire radio_mode,
	input wire tx_enable,
	input wire rx_enable,
	input wire amp_enable,
	input wire baseband_run,
	input wire baseband_clk_en,
	input wire front_end_power,
	input wire eth_phy_power,
	input wire eth_cmd_accept,
	input wire serial_cmd_accept
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_scan_full_rf: assert property (tx_enable |-> rx_enable && amp_enable)
		else $error("transmit without receive chain");
	chk_amps_idle: assert property (amp_enable |-> tx_enable)
		else $error("amplifiers on outside a scan");
	chk_idle_halt: assert property (baseband_run |-> rx_enable && !radio_mode)
		else $error("baseband runs while halted");
	chk_gate_front: assert property (baseband_clk_en == front_end_power)
		else $error("clock gate and front end disagree");
	chk_phy_accept: assert property (eth_phy_power == eth_cmd_accept)
		else $error("ethernet commands without phy power");
	chk_serial_only: assert property (!serial_cmd_accept |-> !eth_phy_power && !front_end_power)
		else $error("circuits powered in deepest sleep");
	chk_radio_boot: assert property (radio_mode |-> !tx_enable && !baseband_run)
		else $error("radar logic on before connect");
	chk_radio_once: assert property (!radio_mode |=> !radio_mode)
		else $error("radio mode came back");
endmodule // pmh_handler_asserts

// File: testbench/pmh_handler_test.sv
// Self-checking bench for the power mode message handler
`timescale 1ns/1ps
`include "pmh_map.vh"
module pmh_handler_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	wire psel, penable, pwrite, pready, pslverr, wake_pin, irq, radio_mode, tx_enable;
	wire rx_enable, amp_enable, baseband_run, baseband_clk_en, front_end_power;
	wire eth_phy_power, eth_cmd_accept, serial_cmd_accept;
	wire [11:0] paddr;
	wire [31:0] pwdata, prdata;
	int miscompares = 0;
	int checks_done = 0;
	logic ien = 1'b0;
	logic [31:0] q;
	typedef struct {logic [15:0] t, k; logic [31:0] a; logic s; logic [15:0] l, et;
		logic [2:0] m; logic [3:0] st, pw;} pmh_row_t;
	pmh_row_t rows [12];
	always #25 pclk = ~pclk;
	pmh_handler u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .wake_pin, .irq, .radio_mode, .tx_enable, .rx_enable, .amp_enable,
		.baseband_run, .baseband_clk_en, .front_end_power, .eth_phy_power, .eth_cmd_accept,
		.serial_cmd_accept);
	pmh_host u_host (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr,
		.pwdata, .wake_pin);
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge u_host.hung) begin
		miscompares++;
		final_report();
	end
	task poll(input int b);
		for (int n = 0; n < 20; n++) begin
			u_host.rd(`PMH_A_IRQ_STAT, q);
			if (q[b] === 1'b1) return;
		end
		miscompares++;
		final_report();
	endtask
	function logic [31:0] pwr();
		return {28'h0, rx_enable, front_end_power, eth_phy_power, serial_cmd_accept};
	endfunction
	task req(input pmh_row_t r);
		u_host.request(r.t, r.k, r.a, r.s, r.l);
		poll(0);
		chk("irq", {31'h0, ien}, {31'h0, irq});
		u_host.rd(`PMH_A_RSP_HDR, q);
		if (r.et !== 16'h0) chk("type", {16'h0, r.et}, {16'h0, q[31:16]});
		chk("track", {16'h0, r.k}, {16'h0, q[15:0]});
		u_host.rd(`PMH_A_RSP_MODE, q);
		chk("mode", {29'h0, r.m}, q);
		u_host.rd(`PMH_A_RSP_STAT, q);
		chk("status", {28'h0, r.st}, q);
		chk("power", {28'h0, r.pw}, pwr());
		u_host.wr(`PMH_A_IRQ_CLR, 32'h1);
	endtask
	initial begin
		rows = '{
			'{16'hf006, 16'h0011, 32'h0, 1'h0, 16'h4, 16'hf106, 3'h0, 4'h0, 4'hf},
			'{16'h1234, 16'h0012, 32'h0, 1'h0, 16'h4, 16'h0, 3'h0, 4'h8, 4'hf},
			'{16'hf006, 16'h0013, 32'h0, 1'h0, 16'h8, 16'hf106, 3'h0, 4'h5, 4'hf},
			'{16'hf005, 16'h0014, 32'h5, 1'h0, 16'h8, 16'hf105, 3'h0, 4'h3, 4'hf},
			'{16'hf005, 16'h0016, 32'h1, 1'h0, 16'h8, 16'hf105, 3'h0, 4'h0, 4'h7},
			'{16'hf003, 16'h0017, 32'h0, 1'h0, 16'h8, 16'h0, 3'h1, 4'h4, 4'h7},
			'{16'hf005, 16'h0018, 32'h2, 1'h0, 16'h8, 16'hf105, 3'h1, 4'h0, 4'h3},
			'{16'h1001, 16'h0019, 32'h0, 1'h0, 16'h8, 16'h1101, 3'h2, 4'h4, 4'h3},
			'{16'hf005, 16'h001a, 32'h3, 1'h0, 16'h8, 16'hf105, 3'h2, 4'h0, 4'h1},
			'{16'hf006, 16'h001b, 32'h0, 1'h0, 16'h4, 16'hf106, 3'h3, 4'h1, 4'h1},
			'{16'hf006, 16'h001c, 32'h0, 1'h1, 16'h4, 16'hf106, 3'h3, 4'h0, 4'h1},
			'{16'hf005, 16'h001d, 32'h0, 1'h1, 16'h8, 16'hf105, 3'h3, 4'h0, 4'hf}};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("radio", 32'h1, {31'h0, radio_mode});
		chk("power", 32'hf, pwr());
		u_host.wr(`PMH_A_IRQ_EN, 32'h0);
		foreach (rows[i]) req(rows[i]);
		chk("radio", 32'h0, {31'h0, radio_mode});
		$display("table done");
		req('{16'hf003, 16'h0020, 32'h0, 1'h0, 16'h8, 16'h0, 3'h0, 4'h0, 4'hf});
		chk("scan", 32'h1, {31'h0, tx_enable & amp_enable & baseband_run});
		u_host.wr(`PMH_A_CTRL, 32'h2);
		@(posedge pclk);
		chk("stop", 32'h0, {31'h0, tx_enable | amp_enable});
		$display("scan done");
		ien = 1'b1;
		u_host.wr(`PMH_A_IRQ_EN, 32'h3);
		u_host.wr(`PMH_A_FAULT, 32'h80000055);
		u_host.request(`PMH_T_QUERY, 16'h0021, 32'h0, 1'b0, `PMH_LEN_SHORT);
		poll(0);
		chk("irq", 32'h1, {31'h0, irq});
		u_host.rd(`PMH_A_RSP_STAT, q);
		chk("status", 32'h80000055, q);
		u_host.wr(`PMH_A_IRQ_CLR, 32'h1);
		@(posedge pclk);
		chk("irq", 32'h0, {31'h0, irq});
		u_host.wr(`PMH_A_FAULT, 32'h0);
		$display("fault done");
		req('{16'hf005, 16'h0023, 32'h4, 1'h0, 16'h8, 16'hf105, 3'h0, 4'h0, 4'h0});
		req('{16'hf005, 16'h0024, 32'h0, 1'h1, 16'h8, 16'hf105, 3'h4, 4'h4, 4'h0});
		u_host.wake();
		poll(1);
		u_host.rd(`PMH_A_RSP_HDR, q);
		chk("notice", {`PMH_T_READY, 16'h0024}, q);
		chk("power", 32'hf, pwr());
		$display("wake done");
		u_host.rd(12'h040, q);
		chk("slverr", 32'h1, {31'h0, u_host.err});
		chk("rdata", 32'h0, q);
		$display("unmapped done");
		final_report();
	end
endmodule // pmh_handler_test
bind pmh_handler pmh_handler_asserts u_chk (.pclk, .presetn, .radio_mode, .tx_enable,
	.rx_enable, .amp_enable, .baseband_run, .baseband_clk_en, .front_end_power,
	.eth_phy_power, .eth_cmd_accept, .serial_cmd_accept);

// File: testbench/pmh_host.sv
// Host model: APB master and wake pin
`timescale 1ns/1ps
`include "pmh_map.vh"
module pmh_host (
	input wire pclk,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [11:0] paddr = 12'h000,
	output logic [31:0] pwdata = 32'h0,
	output logic wake_pin = 1'b0
);
	logic hung = 1'b0;
	logic err;
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 40 && pready !== 1'b1; n++) @(posedge pclk);
		if (pready !== 1'b1) hung = 1'b1;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so no signal is set twice at once
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, q);
	endtask
	task automatic request(input logic [15:0] t, k, input logic [31:0] a, input logic s,
		input logic [15:0] l);
		wr(`PMH_A_REQ_HDR, {t, k});
		wr(`PMH_A_REQ_ARG, a);
		wr(`PMH_A_REQ_LEN, {15'h0, s, l});
		wr(`PMH_A_REQ_GO, 32'h1);
	endtask
	task wake;
		wake_pin <= 1'b1;
		@(posedge pclk);
	endtask
endmodule // pmh_host
